// >>> phy_ctrl_pkg.sv
// constants for the upper half of the phy function control register
package phy_ctrl_pkg;
  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [4:0] PHY_FUNCTION_CONTROL_ADDR = 5'h19;
  localparam int BIT_AUTO_XOVER = 15;
  localparam int BIT_FORCE_XOVER = 14;
  localparam int BIT_PAUSE_RX = 13;
  localparam int BIT_PAUSE_TX = 12;
  localparam int BIT_ERR_INJECT = 11;
  localparam int BIT_SEQ_SELECT = 10;
  localparam int BIT_SELFTEST_RESULT = 9;
  localparam int BIT_SELFTEST_RUN = 8;
  localparam int BIT_STRETCH_BYPASS = 7;
  // pause capability field positions inside the advertisement words
  localparam int ADV_PAUSE = 0;
  localparam int ADV_ASYM = 1;
  // ************************************************************
  // self-test sequences
  // ************************************************************
  localparam int LFSR_W = 15;
  localparam logic [14:0] LFSR_SEED = 15'h7FFF;
  localparam int LONG_TAP_A = 14;
  localparam int LONG_TAP_B = 13;
  localparam int SHORT_TAP_A = 8;
  localparam int SHORT_TAP_B = 4;
  localparam logic [3:0] LONG_ORDER = 4'hF;
  localparam logic [3:0] SHORT_ORDER = 4'h9;
  localparam int ERR_COUNT_W = 16;
  // ************************************************************
  // reset values and timing
  // ************************************************************
  localparam logic [1:0] STRAP_LOAD_CYCLE = 2'h2;
  localparam int CLK_PERIOD_NS = 8;
  localparam int LED_STRETCH_TIME_US = 50;
  localparam int LED_STRETCH_CYCLES = (LED_STRETCH_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int LED_COUNT = 3;
endpackage

// >>> phy_function_control.sv
// upper half of the phy function control register with crossover, pause, self-test and led logic
`timescale 1ns/1ps
module phy_function_control #(
  parameter int STRETCH_CYCLES = phy_ctrl_pkg::LED_STRETCH_CYCLES
) (
  input wire logic clk, // 125 MHz clock
  input wire logic rst_n, // asynchronous reset, active low
  input wire logic [4:0] mgmtAddr, // register address from management frame decoder
  input wire logic mgmtWrEn, // one-cycle write strobe
  input wire logic [15:0] mgmtWrData, // write data
  input wire logic mgmtRdEn, // one-cycle read strobe
  output logic [15:0] mgmtRdData, // read data, bits 6..0 read zero here
  output logic mgmtRdValid, // read data valid pulse
  input wire logic strapAutoCrossover, // strap pin for auto crossover enable
  input wire logic autoNegEnable, // autonegotiation enable from basic control reg
  input wire logic autoSwapRequest, // crossover detector wants swapped pairs
  output logic pairSwap, // 1: receive on line_transmit_pair, transmit on line_receive_pair
  output logic autoCrossoverEnable, // current auto crossover enable
  input wire logic [1:0] localPause, // local_advertisement_reg bits 11:10
  input wire logic [1:0] partnerPause, // partner_ability_reg bits 11:10
  input wire logic hcdFullDuplex, // resolved common technology is full duplex
  output logic pauseRxEnable, // tell mac to honour pause frames
  output logic pauseTxEnable, // tell mac to send pause frames
  output logic selftestTxBit, // self-test stream out
  input wire logic selftestRxBit, // self-test stream back from loop
  output logic [15:0] selftestErrorCount, // error count for diagnostic_control_reg
  input wire logic [2:0] ledRaw, // unstretched led indications
  output logic [2:0] ledOut // led drive
);
  localparam int CW = $clog2(STRETCH_CYCLES + 1);
  localparam logic [CW-1:0] STRETCH_LOAD = CW'(STRETCH_CYCLES);

  typedef struct packed {
    logic autoXoverEn;
    logic forceXover;
    logic injectPend;
    logic seqLong;
    logic run;
    logic stretchBypass;
    logic pass;
    logic pauseRx;
    logic pauseTx;
    logic strapMeta;
    logic strapSync;
    logic [1:0] strapCnt;
    logic strapDone;
    logic [14:0] genLfsr;
    logic [14:0] chkShift;
    logic [4:0] fillCnt;
    logic [15:0] errCount;
    logic txBit;
    logic pairSwap;
    logic [2:0][CW-1:0] stretchCnt;
    logic [2:0] ledOut;
    logic [15:0] rdData;
    logic rdValid;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic wrHit;
    logic genBit;
    logic predBit;
    logic chkErr;
    logic [3:0] order;
    logic [1:0] lp;
    logic [1:0] pp;
    logic rxRes;
    logic txRes;
    logic [15:0] rdWord;
    wrHit = 1'b0;
    genBit = 1'b0;
    predBit = 1'b0;
    chkErr = 1'b0;
    order = 4'h0;
    lp = localPause;
    pp = partnerPause;
    rxRes = 1'b0;
    txRes = 1'b0;
    rdWord = 16'h0000;
    state_next = state_reg;
    wrHit = mgmtWrEn && (mgmtAddr == phy_ctrl_pkg::PHY_FUNCTION_CONTROL_ADDR);

    // strap passes two flops, then is loaded once after reset release
    state_next.strapMeta = strapAutoCrossover;
    state_next.strapSync = state_reg.strapMeta;
    if (!state_reg.strapDone) begin
      state_next.strapCnt = state_reg.strapCnt + 2'h1;
    end

    // self-test generator and self-synchronising checker
    if (state_reg.seqLong) begin
      genBit = state_reg.genLfsr[phy_ctrl_pkg::LONG_TAP_A] ^ state_reg.genLfsr[phy_ctrl_pkg::LONG_TAP_B];
      predBit = state_reg.chkShift[phy_ctrl_pkg::LONG_TAP_A] ^ state_reg.chkShift[phy_ctrl_pkg::LONG_TAP_B];
      order = phy_ctrl_pkg::LONG_ORDER;
    end else begin
      genBit = state_reg.genLfsr[phy_ctrl_pkg::SHORT_TAP_A] ^ state_reg.genLfsr[phy_ctrl_pkg::SHORT_TAP_B];
      predBit = state_reg.chkShift[phy_ctrl_pkg::SHORT_TAP_A] ^ state_reg.chkShift[phy_ctrl_pkg::SHORT_TAP_B];
      order = phy_ctrl_pkg::SHORT_ORDER;
    end
    if (state_reg.run) begin
      state_next.genLfsr = {state_reg.genLfsr[13:0], genBit};
      state_next.chkShift = {state_reg.chkShift[13:0], selftestRxBit};
      if (state_reg.fillCnt != {phy_ctrl_pkg::LONG_ORDER, 1'b0}) begin
        state_next.fillCnt = state_reg.fillCnt + 5'h01;
      end
      // warm-up of two sequence orders: the first bits back are loop-delay filler, not sequence,
      // and must leave the shift register before a prediction is trusted; covers loops up to one order
      chkErr = (state_reg.fillCnt >= {order, 1'b0}) && (predBit != selftestRxBit);
      state_next.txBit = genBit ^ state_reg.injectPend;
      state_next.injectPend = 1'b0;
    end else begin
      state_next.genLfsr = phy_ctrl_pkg::LFSR_SEED;
      state_next.chkShift = '0;
      state_next.fillCnt = 5'h00;
      state_next.txBit = 1'b0;
    end
    if (state_reg.run) begin
      if (chkErr) begin
        state_next.pass = 1'b0;
        if (state_reg.errCount != 16'hFFFF) begin
          state_next.errCount = state_reg.errCount + 16'h0001;
        end
      end
    end else begin
      state_next.pass = 1'b0;
    end

    // auto swap only with autonegotiation running
    state_next.pairSwap = state_reg.forceXover || (state_reg.autoXoverEn && autoNegEnable && autoSwapRequest);

    if (hcdFullDuplex) begin
      if (lp[phy_ctrl_pkg::ADV_PAUSE] && pp[phy_ctrl_pkg::ADV_PAUSE]) begin
        rxRes = 1'b1;
        txRes = 1'b1;
      end else if (!lp[phy_ctrl_pkg::ADV_PAUSE] && lp[phy_ctrl_pkg::ADV_ASYM] && pp[phy_ctrl_pkg::ADV_PAUSE]
                   && pp[phy_ctrl_pkg::ADV_ASYM]) begin
        txRes = 1'b1;
      end else if (lp[phy_ctrl_pkg::ADV_PAUSE] && lp[phy_ctrl_pkg::ADV_ASYM] && !pp[phy_ctrl_pkg::ADV_PAUSE]
                   && pp[phy_ctrl_pkg::ADV_ASYM]) begin
        rxRes = 1'b1;
      end
    end
    state_next.pauseRx = rxRes;
    state_next.pauseTx = txRes;

    for (int i = 0; i < phy_ctrl_pkg::LED_COUNT; i++) begin
      if (ledRaw[i]) begin
        state_next.stretchCnt[i] = STRETCH_LOAD;
      end else if (state_reg.stretchCnt[i] != '0) begin
        state_next.stretchCnt[i] = state_reg.stretchCnt[i] - CW'(1);
      end
      state_next.ledOut[i] = state_reg.stretchBypass ? ledRaw[i] : (ledRaw[i] || (state_reg.stretchCnt[i] != '0));
    end

    // register write; a fresh inject request wins over the clearing above
    if (wrHit) begin
      state_next.autoXoverEn = mgmtWrData[phy_ctrl_pkg::BIT_AUTO_XOVER];
      state_next.forceXover = mgmtWrData[phy_ctrl_pkg::BIT_FORCE_XOVER];
      if (mgmtWrData[phy_ctrl_pkg::BIT_ERR_INJECT]) begin
        state_next.injectPend = 1'b1;
      end
      state_next.seqLong = mgmtWrData[phy_ctrl_pkg::BIT_SEQ_SELECT];
      state_next.run = mgmtWrData[phy_ctrl_pkg::BIT_SELFTEST_RUN];
      state_next.stretchBypass = mgmtWrData[phy_ctrl_pkg::BIT_STRETCH_BYPASS];
      if (mgmtWrData[phy_ctrl_pkg::BIT_SELFTEST_RUN] && !state_reg.run) begin
        state_next.pass = 1'b1;
        state_next.errCount = 16'h0000;
      end
    end

    if (!state_reg.strapDone && state_reg.strapCnt == phy_ctrl_pkg::STRAP_LOAD_CYCLE) begin
      state_next.autoXoverEn = state_reg.strapSync;
      state_next.strapDone = 1'b1;
    end

    // read path
    rdWord[phy_ctrl_pkg::BIT_AUTO_XOVER] = state_reg.autoXoverEn;
    rdWord[phy_ctrl_pkg::BIT_FORCE_XOVER] = state_reg.forceXover;
    rdWord[phy_ctrl_pkg::BIT_PAUSE_RX] = state_reg.pauseRx;
    rdWord[phy_ctrl_pkg::BIT_PAUSE_TX] = state_reg.pauseTx;
    rdWord[phy_ctrl_pkg::BIT_ERR_INJECT] = state_reg.injectPend;
    rdWord[phy_ctrl_pkg::BIT_SEQ_SELECT] = state_reg.seqLong;
    rdWord[phy_ctrl_pkg::BIT_SELFTEST_RESULT] = state_reg.pass;
    rdWord[phy_ctrl_pkg::BIT_SELFTEST_RUN] = state_reg.run;
    rdWord[phy_ctrl_pkg::BIT_STRETCH_BYPASS] = state_reg.stretchBypass;
    state_next.rdValid = mgmtRdEn && (mgmtAddr == phy_ctrl_pkg::PHY_FUNCTION_CONTROL_ADDR);
    if (state_next.rdValid) begin
      state_next.rdData = rdWord;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
      state_reg.genLfsr <= phy_ctrl_pkg::LFSR_SEED;
    end else begin
      state_reg <= state_next;
    end
  end

  assign mgmtRdData = state_reg.rdData;
  assign mgmtRdValid = state_reg.rdValid;
  assign pairSwap = state_reg.pairSwap;
  assign autoCrossoverEnable = state_reg.autoXoverEn;
  assign pauseRxEnable = state_reg.pauseRx;
  assign pauseTxEnable = state_reg.pauseTx;
  assign selftestTxBit = state_reg.txBit;
  assign selftestErrorCount = state_reg.errCount;
  assign ledOut = state_reg.ledOut;
endmodule // phy_function_control

// >>> phy_function_control_chk.sv
// assertions on the ports of the phy function control register
`timescale 1ns/1ps
module phy_function_control_chk (
  input wire logic clk, // clock
  input wire logic rst_n, // reset, active low
  input wire logic [4:0] mgmtAddr, // address
  input wire logic mgmtRdEn, // read strobe
  input wire logic [15:0] mgmtRdData, // read word
  input wire logic mgmtRdValid, // read valid
  input wire logic autoNegEnable, // autoneg on
  input wire logic autoSwapRequest, // detector swap
  input wire logic pairSwap, // pairs crossed
  input wire logic autoCrossoverEnable, // bit 15
  input wire logic [1:0] localPause, // local pause bits
  input wire logic [1:0] partnerPause, // partner pause bits
  input wire logic hcdFullDuplex, // full duplex
  input wire logic pauseRxEnable, // bit 13
  input wire logic pauseTxEnable, // bit 12
  input wire logic [2:0] ledRaw, // raw leds
  input wire logic [2:0] ledOut // led drive
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ************************************************************
  // properties
  // ************************************************************
  property p_rdValid; mgmtRdEn && mgmtAddr == 5'h19 |=> mgmtRdValid; endproperty
  a_rdValid: assert property (p_rdValid) else $error("read gave no valid");
  property p_noValid; !(mgmtRdEn && mgmtAddr == 5'h19) |=> !mgmtRdValid; endproperty
  a_noValid: assert property (p_noValid) else $error("valid without read");
  property p_rdBits;
    mgmtRdValid |-> mgmtRdData[15] == $past(autoCrossoverEnable)
      && mgmtRdData[13:12] == $past({pauseRxEnable, pauseTxEnable});
  endproperty
  a_rdBits: assert property (p_rdBits) else $error("read word disagrees with outputs");
  property p_pauseHd; !hcdFullDuplex |=> !pauseRxEnable && !pauseTxEnable; endproperty
  a_pauseHd: assert property (p_pauseHd) else $error("pause set in half duplex");
  property p_pauseBoth; hcdFullDuplex && localPause[0] && partnerPause[0] |=> pauseRxEnable && pauseTxEnable; endproperty
  a_pauseBoth: assert property (p_pauseBoth) else $error("symmetric pause missing");
  property p_pauseTx;
    hcdFullDuplex && localPause == 2'h2 && partnerPause == 2'h3 |=> pauseTxEnable && !pauseRxEnable;
  endproperty
  a_pauseTx: assert property (p_pauseTx) else $error("transmit only pause wrong");
  property p_swap; autoCrossoverEnable && autoNegEnable && autoSwapRequest |=> pairSwap; endproperty
  a_swap: assert property (p_swap) else $error("auto swap not applied");
  // raw indication must always reach the drive, stretched or not
  property p_led; $past(rst_n) |-> (ledOut & $past(ledRaw)) == $past(ledRaw); endproperty
  a_led: assert property (p_led) else $error("led lost raw indication");
endmodule // phy_function_control_chk
bind phy_function_control phy_function_control_chk u_chk (.*);

// >>> mgmt_host_model.sv
// management host model with self-test loopback
`timescale 1ns/1ps
module mgmt_host_model (
  input wire logic clk, // clock
  output logic [4:0] mgmtAddr, // address
  output logic mgmtWrEn, // write strobe
  output logic [15:0] mgmtWrData, // write data
  output logic mgmtRdEn, // read strobe
  input wire logic [15:0] mgmtRdData, // read word
  input wire logic mgmtRdValid, // read valid
  input wire logic selftestTxBit, // stream out
  output logic selftestRxBit // stream back
);
  initial begin
    mgmtAddr = 5'h00;
    mgmtWrEn = 1'b0;
    mgmtWrData = 16'h0000;
    mgmtRdEn = 1'b0;
    selftestRxBit = 1'b0;
  end
  // one cycle loop delay, changed off the sampling edge
  always @(negedge clk) selftestRxBit <= selftestTxBit;
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    mgmtAddr = a;
    mgmtWrData = d;
    mgmtWrEn = 1'b1;
    @(negedge clk);
    mgmtWrEn = 1'b0;
    // data is stale after the strobe, so show its inverse
    mgmtWrData = ~d;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d = 16'h0000;
    @(negedge clk);
    mgmtAddr = a;
    mgmtRdEn = 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      mgmtRdEn = 1'b0;
      if (mgmtRdValid === 1'b1 && !ok) begin
        ok = 1'b1;
        d = mgmtRdData;
      end
    end
  endtask
endmodule // mgmt_host_model

// >>> phy_function_control_tb.sv
// self-checking bench for the phy function control register
`timescale 1ns/1ps
module phy_function_control_tb;
  logic clk = 1'b0, rst_n = 1'b0, strapAutoCrossover = 1'b1, autoNegEnable = 1'b0, autoSwapRequest = 1'b0;
  logic [1:0] localPause = 2'h0, partnerPause = 2'h0;
  logic hcdFullDuplex = 1'b0, mgmtWrEn, mgmtRdEn, mgmtRdValid, pairSwap, autoCrossoverEnable, rdOk;
  logic pauseRxEnable, pauseTxEnable, selftestTxBit, selftestRxBit;
  logic [4:0] mgmtAddr;
  logic [15:0] mgmtWrData, mgmtRdData, selftestErrorCount, rdWord;
  logic [2:0] ledRaw = 3'h0, ledOut;
  int n_errors = 0, cmp_count = 0;
  always #4 clk = ~clk;
  phy_function_control #(.STRETCH_CYCLES(8)) u_phy_function_control (.*);
  mgmt_host_model u_mgmt_host_model (.*);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [15:0] mask, input logic [15:0] exp);
    u_mgmt_host_model.rd(5'h19, rdWord, rdOk);
    if (rdOk !== 1'b1) begin
      n_errors++;
      wrap_up();
    end else begin
      chk(rdWord & mask, exp);
    end
  endtask
  task automatic t_reset();
    rchk(16'hFF80, 16'h8000);
    u_mgmt_host_model.rd(5'h18, rdWord, rdOk);
    chk(rdOk, 1'b0);
  endtask
  task automatic t_ctrl();
    u_mgmt_host_model.wr(5'h18, 16'h4000);
    rchk(16'hFF80, 16'h8000);
    u_mgmt_host_model.wr(5'h19, 16'h4480);
    rchk(16'hFF80, 16'h4480);
    chk(pairSwap, 1'b1);
    ledRaw = 3'h5;
    @(negedge clk);
    ledRaw = 3'h0;
    @(negedge clk);
    chk(ledOut, 3'h0);
    u_mgmt_host_model.wr(5'h19, 16'h0000);
    ledRaw = 3'h5;
    @(negedge clk);
    ledRaw = 3'h0;
    repeat (3) @(negedge clk);
    chk(ledOut, 3'h5);
    repeat (12) @(negedge clk);
    chk({ledOut, pairSwap}, 4'h0);
  endtask
  task automatic t_xover();
    autoNegEnable = 1'b1;
    autoSwapRequest = 1'b1;
    repeat (2) @(negedge clk);
    chk(pairSwap, 1'b0);
    u_mgmt_host_model.wr(5'h19, 16'h8000);
    repeat (2) @(negedge clk);
    chk(pairSwap, 1'b1);
    autoNegEnable = 1'b0;
    repeat (2) @(negedge clk);
    chk({pairSwap, autoCrossoverEnable}, 2'h1);
    u_mgmt_host_model.wr(5'h19, 16'h0000);
    repeat (2) @(negedge clk);
    chk({pairSwap, autoCrossoverEnable}, 2'h0);
  endtask
  task automatic t_pause();
    logic rx, tx;
    for (int i = 0; i < 32; i++) begin
      localPause = i[1:0];
      partnerPause = i[3:2];
      hcdFullDuplex = i[4];
      rx = i[4] && ((i[0] && i[2]) || (i[1:0] == 2'h3 && i[3:2] == 2'h2));
      tx = i[4] && ((i[0] && i[2]) || (i[1:0] == 2'h2 && i[3:2] == 2'h3));
      repeat (2) @(negedge clk);
      chk({pauseRxEnable, pauseTxEnable}, {rx, tx});
      rchk(16'h3000, {2'h0, rx, tx, 12'h000});
    end
  endtask
  task automatic t_selftest();
    u_mgmt_host_model.wr(5'h19, 16'h0500);
    // long sequence from the all-ones seed opens with fourteen zeros
    repeat (6) @(negedge clk);
    chk(selftestTxBit, 1'b0);
    repeat (34) @(negedge clk);
    rchk(16'h0F00, 16'h0700);
    u_mgmt_host_model.wr(5'h19, 16'h0D00);
    // third error only when the flipped bit reaches the far tap
    repeat (25) @(negedge clk);
    rchk(16'h0F00, 16'h0500);
    chk(selftestErrorCount, 16'h0003);
    u_mgmt_host_model.wr(5'h19, 16'h0000);
    rchk(16'h0F00, 16'h0000);
    chk(selftestTxBit, 1'b0);
    u_mgmt_host_model.wr(5'h19, 16'h0100);
    // short sequence turns to one at its sixth bit
    repeat (6) @(negedge clk);
    chk(selftestTxBit, 1'b1);
    repeat (24) @(negedge clk);
    rchk(16'h0F00, 16'h0300);
    chk(selftestErrorCount, 16'h0000);
    u_mgmt_host_model.wr(5'h19, 16'h0000);
  endtask
  task automatic t_strap();
    hcdFullDuplex = 1'b0;
    strapAutoCrossover = 1'b0;
    rst_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    rchk(16'hFF80, 16'h0000);
    // read-only bits ignore writes
    u_mgmt_host_model.wr(5'h19, 16'h3200);
    rchk(16'hFF80, 16'h0000);
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    // strap lands a few edges after release, so hold off the first access
    repeat (5) @(negedge clk);
    t_reset();
    t_ctrl();
    t_xover();
    t_pause();
    t_selftest();
    t_strap();
    wrap_up();
  end
endmodule // phy_function_control_tb
